// >>> hdl/plc_ctrl.sv
`timescale 1ns/100ps
// Functional notes
// - First high level from shutdown enables device with all currents zero.
// - Line low longer than shutdown time starts shutdown; it proceeds even if the line returns high.
// - Power-down completes one millisecond later, clearing registers and sinks.
// - Falling edges are counted; N address pulses select register N, one to six.
// - Pulse phases lie between 200 ns and 100 us; shorter glitches ignored.
// - No data edge within 1000 us abandons transaction, back to address wait.
// - Selecting a register clears it; it stays zero without data.
// - Programming sequencer starts in the address-waiting state.
// - Six registers: five of four bits, one of one bit.
// - Low supply disables all channels and resets every register.
// - In shutdown every sink output is off, high impedance.
// - Pump starts in 1x and stays while regulation holds.
// - Regulation failure in 1x steps to 1.33x after the qualification delay.
// - Continued failure steps to 1.5x then 2x, one step per delay.
// - Sufficient supply returns directly to 1x; no other downward step.
// - Register one bit 3 selects high range; zero divides currents by eight.
// - Register one bits 2..0 enable banks A, B, C.
// - Lockout bit set by one pulse, cleared otherwise; blocks return to 1x.
// - Addressing register six resets the pump to 1x.
module plc_ctrl #(
    parameter int OFF_CYC  = plc_pkg::OFF_CYC,
    parameter int PDN_CYC  = plc_pkg::PDN_CYC,
    parameter int GAP_CYC  = plc_pkg::GAP_CYC,
    parameter int QUAL_CYC = plc_pkg::QUAL_CYC
) (
    // Clock, reset, enable
    input  wire logic                sys_clk,
    input  wire logic                rstn,
    input  wire logic                ce,
    // Pins and analog status, asynchronous
    input  wire logic                prog_pin,
    input  wire logic                low_supply_lockout,
    input  wire logic                reg_ok,
    input  wire logic                supply_1x_ok,
    // Outputs
    output logic                     device_on,
    output logic [5:0]               led_sink_outputs,
    output plc_pkg::plc_regs_t       cfg_regs,
    output plc_pkg::plc_mode_t       pump_mode
);

    localparam logic [plc_pkg::LOW_W-1:0] OFF_LAST = plc_pkg::LOW_W'(OFF_CYC - 1);
    localparam logic [plc_pkg::LOW_W-1:0] PDN_LAST = plc_pkg::LOW_W'(PDN_CYC - 1);
    localparam logic [plc_pkg::HI_W-1:0]  GAP_LAST = plc_pkg::HI_W'(GAP_CYC - 1);

    function automatic logic [3:0] burst_code(input logic [4:0] pulses);
        burst_code = 4'h0 - pulses[3:0];
    endfunction

    // ========================================================
    // Input synchronisers.
    logic [3:0] sync1;
    logic [3:0] sync2;
    wire  [3:0] raw_in = {supply_1x_ok, reg_ok, low_supply_lockout, prog_pin};

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end else if (ce) begin
            sync1 <= raw_in;
            sync2 <= sync1;
        end
    end

    wire prog_s   = sync2[0];
    wire low_supply_lockout_s   = sync2[1];
    wire reg_ok_s = sync2[2];
    wire sup1x_s  = sync2[3];

    // ========================================================
    // Glitch filter: a new level must stand for the minimum pulse time.
    logic       prog_lvl;
    logic [2:0] flt_cnt;

    wire flt_take = ce && (prog_s != prog_lvl) && (flt_cnt == plc_pkg::FLT_LAST);
    wire lvl_fall = flt_take && prog_lvl;
    wire lvl_rise = flt_take && !prog_lvl;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            prog_lvl <= 1'b0;
            flt_cnt  <= 3'h0;
        end else if (ce) begin
            flt_cnt <= (prog_s == prog_lvl || flt_take) ? 3'h0 : flt_cnt + 3'h1;
            if (flt_take) prog_lvl <= prog_s;
        end
    end

    // ========================================================
    // Enable and shutdown timing.
    logic                      pdn_pending;
    logic [plc_pkg::LOW_W-1:0] low_cnt;

    wire shut_now  = ce && device_on && pdn_pending && (low_cnt == PDN_LAST);
    wire clear_all = shut_now || low_supply_lockout_s || !device_on;
    wire active    = device_on && !low_supply_lockout_s;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            device_on   <= 1'b0;
            pdn_pending <= 1'b0;
            low_cnt     <= '0;
        end else if (ce) begin
            if (!device_on) begin
                pdn_pending <= 1'b0;
                low_cnt     <= '0;
                device_on   <= prog_lvl;
            end else if (pdn_pending) begin
                if (low_cnt == PDN_LAST) device_on <= 1'b0;
                low_cnt <= low_cnt + 1'b1;
            end else if (prog_lvl) begin
                low_cnt <= '0;
            end else if (low_cnt == OFF_LAST) begin
                pdn_pending <= 1'b1;
                low_cnt     <= '0;
            end else begin
                low_cnt <= low_cnt + 1'b1;
            end
        end
    end

    // ========================================================
    // Programming sequencer.
    plc_pkg::plc_state_t      state;
    plc_pkg::plc_state_t      next_state;
    logic [4:0]               pcount;
    logic [2:0]               addr;
    logic [plc_pkg::HI_W-1:0] hi_cnt;

    wire hi_done    = prog_lvl && (hi_cnt == plc_pkg::PULSE_LAST);
    wire addr_end   = (state == plc_pkg::ST_ADDR_CNT) && hi_done;
    wire data_end   = (state == plc_pkg::ST_DATA_CNT) && hi_done;
    wire gap_end    = (state == plc_pkg::ST_DATA_WAIT) && prog_lvl && (hi_cnt == GAP_LAST);
    wire addr_valid = (pcount >= plc_pkg::ADDR_FIRST) && (pcount <= plc_pkg::ADDR_LAST);
    wire addr_sel   = ce && addr_end && addr_valid && !clear_all;
    wire commit     = ce && data_end && !clear_all;
    wire burst_new  = (state == plc_pkg::ST_ADDR) || (state == plc_pkg::ST_DATA_WAIT);
    wire restart    = addr_sel && (pcount == plc_pkg::ADDR_LOCK);

    always_comb begin
        next_state = state;
        case (state)
            plc_pkg::ST_ADDR: begin
                if (lvl_fall) next_state = plc_pkg::ST_ADDR_CNT;
            end
            plc_pkg::ST_ADDR_CNT: begin
                if (addr_end) next_state = addr_valid ? plc_pkg::ST_DATA_WAIT : plc_pkg::ST_ADDR;
            end
            plc_pkg::ST_DATA_WAIT: begin
                if (lvl_fall) next_state = plc_pkg::ST_DATA_CNT;
                else if (gap_end) next_state = plc_pkg::ST_ADDR;
            end
            plc_pkg::ST_DATA_CNT: begin
                if (data_end) next_state = plc_pkg::ST_ADDR;
            end
            default: next_state = plc_pkg::ST_ADDR;
        endcase
        if (clear_all) next_state = plc_pkg::ST_ADDR;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state  <= plc_pkg::ST_ADDR;
            pcount <= 5'h00;
            addr   <= 3'h0;
            hi_cnt <= '0;
        end else if (ce) begin
            state <= next_state;
            if (clear_all) pcount <= 5'h00;
            else if (lvl_fall) pcount <= burst_new ? 5'h01 : pcount + 5'h01;
            if (addr_sel) addr <= pcount[2:0];
            if (!prog_lvl || lvl_rise) hi_cnt <= '0;
            else if (hi_cnt != plc_pkg::HI_SAT) hi_cnt <= hi_cnt + 1'b1;
        end
    end

    // ========================================================
    // Register file: five four-bit codes and the lockout bit.
    logic [3:0] code_q [1:5];
    logic       lockout_q;
    wire        lock_load = commit && (addr == plc_pkg::ADDR_LOCK[2:0]);

    for (genvar i = 1; i <= 5; i++) begin : g_code
        always_ff @(posedge sys_clk) begin
            if (!rstn) begin
                code_q[i] <= plc_pkg::CODE_RESET;
            end else if (ce) begin
                if (clear_all) code_q[i] <= plc_pkg::CODE_RESET;
                else if (addr_sel && pcount == 5'(i)) code_q[i] <= plc_pkg::CODE_RESET;
                else if (commit && addr == 3'(i)) code_q[i] <= burst_code(pcount);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            lockout_q <= 1'b0;
        end else if (ce) begin
            if (clear_all || restart) lockout_q <= 1'b0;
            else if (lock_load) lockout_q <= (pcount == plc_pkg::LOCK_SET_PULSES);
        end
    end

    assign cfg_regs = {code_q[1], code_q[2], code_q[3], code_q[4], code_q[5], lockout_q};

    // ========================================================
    // Sink enables, two channels per bank, A in the low bits.
    wire [5:0] next_sinks = active ? {{2{cfg_regs.bank_c_on}},
                                      {2{cfg_regs.bank_b_on}},
                                      {2{cfg_regs.bank_a_on}}} : 6'h00;

    always_ff @(posedge sys_clk) begin
        if (!rstn) led_sink_outputs <= 6'h00;
        else if (ce) led_sink_outputs <= next_sinks;
    end

    plc_pump #(
        .QUAL_CYC     (QUAL_CYC)
    ) u_pump (
        .sys_clk      (sys_clk),
        .rstn         (rstn),
        .ce           (ce),
        .run          (active),
        .restart      (restart),
        .lockout      (lockout_q),
        .reg_ok       (reg_ok_s),
        .supply_1x_ok (sup1x_s),
        .mode         (pump_mode)
    );

    // ========================================================
    // Checks.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_enable_zero;
        $rose(device_on) |-> cfg_regs == '0 && led_sink_outputs == 6'h00;
    endproperty
    a_enable_zero: assert property (p_enable_zero) else $error("enabled with nonzero setup");
    property p_off_time;
        $rose(pdn_pending) |-> $past(low_cnt) == OFF_LAST && !$past(prog_lvl);
    endproperty
    a_off_time: assert property (p_off_time) else $error("shutdown started early");
    property p_power_down;
        $fell(device_on) |-> cfg_regs == '0 ##1 led_sink_outputs == 6'h00;
    endproperty
    a_power_down: assert property (p_power_down) else $error("power-down left state");
    property p_glitch;
        $changed(prog_lvl) |-> $past(flt_cnt) == plc_pkg::FLT_LAST;
    endproperty
    a_glitch: assert property (p_glitch) else $error("short pulse accepted");
    property p_addr_count;
        state == plc_pkg::ST_ADDR_CNT && lvl_fall && !clear_all |=> pcount == 5'($past(pcount) + 5'h01);
    endproperty
    a_addr_count: assert property (p_addr_count) else $error("address edge not counted");
    property p_gap_abort;
        ce && gap_end && !clear_all |=> state == plc_pkg::ST_ADDR;
    endproperty
    a_gap_abort: assert property (p_gap_abort) else $error("data wait not abandoned");
    property p_sel_clear;
        addr_sel && pcount == 5'h01 |=> cfg_regs.current_range_select == 1'b0 && !cfg_regs.bank_a_on;
    endproperty
    a_sel_clear: assert property (p_sel_clear) else $error("selected register not cleared");
    property p_start_addr;
        $rose(rstn) |-> state == plc_pkg::ST_ADDR;
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("sequencer not in address wait");
    property p_low_supply_lockout;
        ce && low_supply_lockout_s |=> cfg_regs == '0 && led_sink_outputs == 6'h00;
    endproperty
    a_low_supply_lockout: assert property (p_low_supply_lockout) else $error("low supply did not clear");
    property p_hiz;
        !device_on [*2] |-> led_sink_outputs == 6'h00;
    endproperty
    a_hiz: assert property (p_hiz) else $error("sink on in shutdown");
    property p_data_code;
        commit && addr == 3'h2 |=> cfg_regs.global_code == burst_code($past(pcount));
    endproperty
    a_data_code: assert property (p_data_code) else $error("data code wrong");

    c_addr_sel: cover property (addr_sel);
    c_commit:   cover property (commit && addr == 3'h1);
    c_lockout:  cover property (commit && addr == 3'h6);
    c_shutdown: cover property ($fell(device_on));

endmodule

// >>> hdl/plc_pump.sv
`timescale 1ns/100ps
// ============================================================
// Charge-pump mode stepper.
module plc_pump #(
    parameter int QUAL_CYC = plc_pkg::QUAL_CYC
) (
    // Clock, reset, enable
    input  wire logic            sys_clk,
    input  wire logic            rstn,
    input  wire logic            ce,
    // Control
    input  wire logic            run,
    input  wire logic            restart,
    input  wire logic            lockout,
    input  wire logic            reg_ok,
    input  wire logic            supply_1x_ok,
    // Mode
    output plc_pkg::plc_mode_t   mode
);

    localparam logic [plc_pkg::LOW_W-1:0] QUAL_LAST = plc_pkg::LOW_W'(QUAL_CYC - 1);

    logic [plc_pkg::LOW_W-1:0] qual_cnt;
    plc_pkg::plc_mode_t        next_mode;

    wire hold_1x = !run || restart;
    wire back_1x = supply_1x_ok && !lockout && (mode != plc_pkg::MODE_1X);
    wire step_up = !reg_ok && (mode != plc_pkg::MODE_2X) && (qual_cnt == QUAL_LAST);
    wire qual_clr = hold_1x || reg_ok || back_1x || step_up || (mode == plc_pkg::MODE_2X);

    // ========================================================
    // Mode selection.
    always_comb begin
        next_mode = mode;
        if (hold_1x || back_1x) begin
            next_mode = plc_pkg::MODE_1X;
        end else if (step_up) begin
            case (mode)
                plc_pkg::MODE_1X:    next_mode = plc_pkg::MODE_1P33X;
                plc_pkg::MODE_1P33X: next_mode = plc_pkg::MODE_1P5X;
                plc_pkg::MODE_1P5X:  next_mode = plc_pkg::MODE_2X;
                default:             next_mode = plc_pkg::MODE_2X;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            mode     <= plc_pkg::MODE_1X;
            qual_cnt <= '0;
        end else if (ce) begin
            mode     <= next_mode;
            qual_cnt <= qual_clr ? '0 : qual_cnt + 1'b1;
        end
    end

    // ========================================================
    // Checks.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    property p_pump_restart;
        ce && restart |=> mode == plc_pkg::MODE_1X;
    endproperty
    a_pump_restart: assert property (p_pump_restart) else $error("pump not reset to 1x");

    property p_pump_idle;
        !run [*2] |-> mode == plc_pkg::MODE_1X;
    endproperty
    a_pump_idle: assert property (p_pump_idle) else $error("pump left 1x while idle");

    property p_pump_qual;
        (mode > $past(mode)) |-> $past(qual_cnt) == QUAL_LAST && !$past(reg_ok);
    endproperty
    a_pump_qual: assert property (p_pump_qual) else $error("pump stepped early");

    property p_pump_one_step;
        (mode > $past(mode)) |-> int'(mode) == int'($past(mode)) + 1;
    endproperty
    a_pump_one_step: assert property (p_pump_one_step) else $error("pump skipped a mode");

    property p_pump_down;
        (mode < $past(mode)) |-> mode == plc_pkg::MODE_1X;
    endproperty
    a_pump_down: assert property (p_pump_down) else $error("pump stepped down not to 1x");

    property p_pump_lock;
        ce && run && !restart && lockout && mode != plc_pkg::MODE_1X |=> mode != plc_pkg::MODE_1X;
    endproperty
    a_pump_lock: assert property (p_pump_lock) else $error("pump returned to 1x under lockout");

    c_pump_2x: cover property (mode == plc_pkg::MODE_2X);

endmodule

// >>> include/plc_pkg.sv
// ============================================================
// Shared constants and types of the pulse-count programmer.
package plc_pkg;

    // ========================================================
    // Clock and times.
    localparam int CLK_PERIOD_NS  = 40;
    localparam int PULSE_MIN_NS   = 200;
    localparam int PULSE_MAX_US   = 100;
    localparam int OFF_TIME_US    = 1500;
    localparam int PDN_DELAY_MS   = 1;
    localparam int GAP_MAX_US     = 1000;
    localparam int QUAL_DELAY_US  = 400;

    // Least times round up, longest times round down.
    localparam int FLT_CYC   = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CYC = (PULSE_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int OFF_CYC   = (OFF_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PDN_CYC   = (PDN_DELAY_MS * 1000000) / CLK_PERIOD_NS;
    localparam int GAP_CYC   = (GAP_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int QUAL_CYC  = (QUAL_DELAY_US * 1000) / CLK_PERIOD_NS;

    // ========================================================
    // Counter widths, terminal values and register map.
    localparam int LOW_W = 17;
    localparam int HI_W  = 15;
    localparam logic [2:0]      FLT_LAST   = 3'(FLT_CYC - 1);
    localparam logic [HI_W-1:0] PULSE_LAST = HI_W'(PULSE_CYC - 1);
    localparam logic [HI_W-1:0] HI_SAT     = 15'h7FFF;
    localparam logic [4:0]      ADDR_FIRST = 5'h01;
    localparam logic [4:0]      ADDR_LAST  = 5'h06;
    localparam logic [4:0]      ADDR_LOCK  = 5'h06;
    localparam logic [4:0]      LOCK_SET_PULSES = 5'h01;
    localparam logic [3:0]      CODE_RESET = 4'h0;

    // ========================================================
    // Types.
    typedef enum logic [1:0] {
        ST_ADDR,
        ST_ADDR_CNT,
        ST_DATA_WAIT,
        ST_DATA_CNT
    } plc_state_t;

    typedef enum logic [1:0] {
        MODE_1X,
        MODE_1P33X,
        MODE_1P5X,
        MODE_2X
    } plc_mode_t;

    typedef struct packed {
        logic       current_range_select;
        logic       bank_a_on;
        logic       bank_b_on;
        logic       bank_c_on;
        logic [3:0] global_code;
        logic [3:0] bank_a_code;
        logic [3:0] bank_b_code;
        logic [3:0] bank_c_code;
        logic       downshift_lockout;
    } plc_regs_t;

endpackage

// >>> testbench/plc_host.sv
`timescale 1ns/100ps
// ============================================================
// Host driving the program line.
module plc_host (
    // Clock
    input  wire logic sys_clk,
    // Line
    output logic      prog_pin
);
    initial prog_pin = 1'b0;

    // Level changes land just after an edge and stand n cycles.
    task automatic hold(input logic lvl, input int n);
        prog_pin <= lvl;
        repeat (n) @(posedge sys_clk) #1;
    endtask

    task automatic burst(input int n);
        for (int i = 0; i < n; i++) begin
            hold(1'b0, 10);
            hold(1'b1, 10);
        end
    endtask

    // Host gaps are scaled to the shortened gap counter of the bench.
    task automatic write(input int a, input int p);
        burst(a);
        if (p == 0) begin
            hold(1'b1, 3300);
        end else begin
            hold(1'b1, 2700);
            burst(p);
            hold(1'b1, 3000);
        end
    endtask
endmodule

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
// ============================================================
// Self-checking bench of the programmer.
module tb_top;
    logic               sys_clk;
    logic               rstn;
    logic               ce;
    logic               prog_pin;
    logic               low_supply_lockout;
    logic               reg_ok;
    logic               supply_1x_ok;
    logic               device_on;
    logic [5:0]         led_sink_outputs;
    plc_pkg::plc_regs_t cfg_regs;
    plc_pkg::plc_mode_t pump_mode;
    plc_pkg::plc_regs_t exp;
    int                 fails;
    int                 num_checks;
    int                 n;

    plc_ctrl #(.OFF_CYC(40), .PDN_CYC(30), .GAP_CYC(3000), .QUAL_CYC(20)) plc_ctrl_inst (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .prog_pin(prog_pin),
        .low_supply_lockout(low_supply_lockout), .reg_ok(reg_ok),
        .supply_1x_ok(supply_1x_ok), .device_on(device_on),
        .led_sink_outputs(led_sink_outputs), .cfg_regs(cfg_regs), .pump_mode(pump_mode));
    plc_host plc_host_inst (.sys_clk(sys_clk), .prog_pin(prog_pin));

    always #20 sys_clk = ~sys_clk;

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [20:0] g, input logic [20:0] e);
        num_checks++;
        if (g !== e) begin
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
            fails++;
        end
    endtask

    task automatic wait_mode(input plc_pkg::plc_mode_t m, input int lim);
        for (n = 1; n <= lim; n++) begin
            @(posedge sys_clk) #1;
            if (pump_mode === m) return;
        end
        chk(21'(pump_mode), 21'(m));
        tally_and_finish;
    endtask

    task automatic put(input int a, input int p);
        logic [3:0] v;
        v = 4'(16 - p);
        case (a)
            1: {exp.current_range_select, exp.bank_a_on, exp.bank_b_on, exp.bank_c_on} = v;
            2: exp.global_code = v;
            3: exp.bank_a_code = v;
            4: exp.bank_b_code = v;
            5: exp.bank_c_code = v;
            6: exp.downshift_lockout = (p == 1);
            default: ;
        endcase
    endtask

    task automatic t_power;
        chk(cfg_regs, '0);
        chk(21'(pump_mode), 21'(plc_pkg::MODE_1X));
        plc_host_inst.hold(1'b1, 300);
        chk(21'({device_on, led_sink_outputs}), 21'h000040);
    endtask

    task automatic t_regs;
        int tab [9][2] = '{'{1, 9}, '{2, 1}, '{3, 16}, '{4, 3}, '{5, 15},
                           '{6, 1}, '{7, 0}, '{4, 0}, '{2, 0}};
        foreach (tab[i]) begin
            plc_host_inst.write(tab[i][0], tab[i][1]);
            put(tab[i][0], tab[i][1]);
            chk(cfg_regs, exp);
        end
    endtask

    task automatic t_glitch;
        plc_host_inst.burst(3);
        plc_host_inst.hold(1'b0, 2);
        plc_host_inst.hold(1'b1, 2700);
        plc_host_inst.burst(2);
        plc_host_inst.hold(1'b0, 2);
        plc_host_inst.hold(1'b1, 3000);
        put(3, 2);
        chk(cfg_regs, exp);
    endtask

    task automatic t_pump;
        reg_ok = 1'b0;
        wait_mode(plc_pkg::MODE_1P33X, 60);
        chk(21'(n >= 20), 21'h1);
        wait_mode(plc_pkg::MODE_1P5X, 60);
        chk(21'(n >= 15), 21'h1);
        wait_mode(plc_pkg::MODE_2X, 60);
        supply_1x_ok = 1'b1;
        repeat (60) @(posedge sys_clk) #1;
        chk(21'(pump_mode), 21'(plc_pkg::MODE_2X));
        supply_1x_ok = 1'b0;
        reg_ok = 1'b1;
        plc_host_inst.write(6, 2);
        put(6, 2);
        chk(21'(pump_mode), 21'(plc_pkg::MODE_1X));
        chk(cfg_regs, exp);
        reg_ok = 1'b0;
        wait_mode(plc_pkg::MODE_1P33X, 60);
        supply_1x_ok = 1'b1;
        wait_mode(plc_pkg::MODE_1X, 8);
        supply_1x_ok = 1'b0;
        wait_mode(plc_pkg::MODE_1P33X, 60);
        low_supply_lockout = 1'b1;
        repeat (6) @(posedge sys_clk) #1;
        chk(cfg_regs, '0);
        chk(21'({led_sink_outputs, pump_mode}), 21'(plc_pkg::MODE_1X));
        low_supply_lockout = 1'b0;
        reg_ok = 1'b1;
    endtask

    task automatic t_shut;
        plc_host_inst.write(1, 1);
        plc_host_inst.write(2, 1);
        plc_host_inst.hold(1'b0, 50);
        chk(21'(device_on), 21'h1);
        for (n = 0; n < 60 && device_on !== 1'b0; n++) @(posedge sys_clk) #1;
        chk(21'(device_on), 21'h0);
        if (device_on !== 1'b0) tally_and_finish;
        @(posedge sys_clk) #1;
        chk(cfg_regs, '0);
        chk(21'(led_sink_outputs), 21'h0);
    endtask

    // A low enable must freeze every counter, so a long low line goes unseen.
    task automatic t_freeze;
        ce <= 1'b0;
        plc_host_inst.hold(1'b0, 100);
        plc_host_inst.hold(1'b1, 20);
        ce <= 1'b1;
        repeat (10) @(posedge sys_clk) #1;
        chk(21'(device_on), 21'h1);
        chk(cfg_regs, exp);
    endtask

    // A reset in mid-run clears everything; the held-high line then re-enables.
    task automatic t_reset;
        plc_host_inst.write(1, 3);
        chk(21'(led_sink_outputs), 21'h000033);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk) #1;
        chk(21'({device_on, led_sink_outputs, pump_mode}), 21'h0);
        chk(cfg_regs, '0);
        rstn <= 1'b1;
        plc_host_inst.hold(1'b1, 300);
        chk(21'({device_on, led_sink_outputs}), 21'h000040);
    endtask

    initial begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        ce = 1'b1;
        low_supply_lockout = 1'b0;
        reg_ok = 1'b1;
        supply_1x_ok = 1'b0;
        exp = '0;
        fails = 0;
        num_checks = 0;
        repeat (5) @(posedge sys_clk);
        #1 rstn = 1'b1;
        t_power;
        t_regs;
        t_glitch;
        t_freeze;
        t_pump;
        t_reset;
        t_shut;
        tally_and_finish;
    end
endmodule
